// >>> src/pin_select_defines.vh
// Constants for the clock-output and port pin select block.
`ifndef PIN_SELECT_DEFINES_VH
`define PIN_SELECT_DEFINES_VH
// ==========================================================
// Register indices and byte addresses
`define CLOCK_OUT_SELECT_INDEX 4'h a
`define PORT_C_SELECT_INDEX 4'h b
`define CLOCK_OUT_SELECT_ADDR 32'h0000_0028
`define PORT_C_SELECT_ADDR 32'h0000_002c
// ==========================================================
// Field positions and reset values
`define CLK_SRC_LSB 0
`define CLK_SRC_MSB 4
`define CLK_DISABLE_BIT 5
`define PORT_B_ALT_LSB 6
`define PORT_B_ALT_MSB 9
`define CLOCK_OUT_SELECT_WIDTH 10
`define PORT_C_SELECT_WIDTH 4
`define CLOCK_OUT_SELECT_RESET 10'h020
`define PORT_C_SELECT_RESET 4'h0
// ==========================================================
// Clock-output source codes
`define CLK_SRC_SYSTEM 5'h00
`define CLK_SRC_OSCILLATOR 5'h07
`define CLK_SRC_SYNTH 5'h08
`define CLK_SRC_ADC_A 5'h10
`define CLK_SRC_ADC_B 5'h11
// ==========================================================
// Bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> src/clock_out_and_port_pin_select.v
// Clock-output multiplexer and port-B / port-C pin function select with AXI4-Lite registers.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defines.vh"

// Behaviour
// - Clock pin carries clock chosen by 5-bit source field; resets to system clock.
// - Codes 00111, 01000, 10000, 10001 give oscillator, synthesiser, converter A, B.
// - Disable bit 0 drives clock pin, 1 floats it; resets to 1.
// - Reserved bits of both select registers read zero and ignore writes.
// - Port-B pin 7 peripheral output is address 23, or master oscillator.
// - Port-B pin 6 peripheral output is address 22, or secondary system clock.
// - Port-B pin 5 peripheral output is address 21, or system clock.
// - Port-B pin 4 peripheral output is address 20, or prescaler clock.
// - Port-B peripheral enable wins; alternate choice applies only in peripheral mode.
// - Port-C pin 3 is decoder home or timer channel 3, else SPI select.
// - Port-C pin 2 is decoder index or timer channel 2, else SPI data out.
// - Port-C pin 1 is decoder phase B or timer channel 1, else SPI data in.
// - Port-C pin 0 is decoder phase A or timer channel 0, else SPI clock.
// - Port-C pin without peripheral enable is GPIO steered by its direction bit.
// - Peripheral with select 0 is timer input or output per timer enable.
// - Peripheral with select 1 carries SPI signal, direction from SPI unit.
// - Decoder only samples port-C pins and never drives them.
// - Each port-C pin has its own enable, direction, select and timer enable.
module clock_out_and_port_pin_select
(
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire system_clock,
    input wire oscillator_clock,
    input wire clock_generator_fout,
    input wire adc_a_clock,
    input wire adc_b_clock,
    input wire master_oscillator_clock,
    input wire secondary_system_clock,
    input wire clock_generator_prescaler,
    output reg clock_output_pin_o,
    output reg clock_output_pin_oe,
    input wire [3:0] port_b_peripheral_enable,
    input wire [3:0] port_b_direction,
    input wire [3:0] port_b_gpio_out,
    input wire [3:0] address_high,
    output reg [3:0] port_b_pin_o,
    output reg [3:0] port_b_pin_oe,
    input wire [3:0] port_c_peripheral_enable,
    input wire [3:0] port_c_direction,
    input wire [3:0] port_c_gpio_out,
    input wire [3:0] timer_output_enable,
    input wire [3:0] timer_b_out,
    input wire [3:0] spi2_out,
    input wire [3:0] spi2_oe,
    input wire [3:0] port_c_pin_i,
    output reg [3:0] port_c_pin_o,
    output reg [3:0] port_c_pin_oe,
    output reg [3:0] port_c_gpio_in,
    output reg [3:0] timer_b_in,
    output reg [3:0] decoder_in,
    output reg [3:0] spi2_in
);

    // ==========================================================
    // Address decoding and write merging helpers

    // Word index of a byte address; upper bits must be zero to hit a register.
    function [3:0] reg_index;
        input [31:0] addr;
        begin
            if (addr[31:6] == 26'h000_0000)
                reg_index = addr[5:2];
            else
                reg_index = 4'h0;
        end
    endfunction

    // Merge the low two byte lanes of a write into a 16-bit register image.
    function [15:0] merge_lanes;
        input [15:0] old_val;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge_lanes = old_val;
            if (strb[0])
                merge_lanes[7:0] = data[7:0];
            if (strb[1])
                merge_lanes[15:8] = data[15:8];
        end
    endfunction

    // ==========================================================
    // Register storage

    reg [9:0] clock_out_select_reg;
    reg [3:0] port_c_function_select_reg;
    reg [31:0] wr_addr_reg;
    reg [31:0] wr_data_reg;
    reg [3:0] wr_strb_reg;
    reg aw_got_reg;
    reg w_got_reg;
    reg [15:0] clk_merge;
    reg [15:0] gps_merge;
    wire [3:0] wr_index;
    wire [3:0] rd_index;

    assign wr_index = reg_index(wr_addr_reg);
    assign rd_index = reg_index(s_axi_araddr);

    // Write images; only implemented bits are kept so reserved bits stay zero.
    always @*
    begin
        clk_merge = merge_lanes({6'h00, clock_out_select_reg}, wr_data_reg, wr_strb_reg);
        gps_merge = merge_lanes({12'h000, port_c_function_select_reg}, wr_data_reg, wr_strb_reg);
    end

    // ==========================================================
    // AXI4-Lite write channel

    // Address and data are taken in either order; the response follows both.
    // Each ready drops after its handshake so only one write is under way.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
            wr_data_reg <= 32'h0000_0000;
            wr_strb_reg <= 4'h0;
            clock_out_select_reg <= `CLOCK_OUT_SELECT_RESET;
            port_c_function_select_reg <= `PORT_C_SELECT_RESET;
        end
        else
        begin
            // Readies rise one cycle after reset and after each response.
            if (!aw_got_reg && !s_axi_bvalid && !s_axi_awready)
                s_axi_awready <= 1'b1;
            if (!w_got_reg && !s_axi_bvalid && !s_axi_wready)
                s_axi_wready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready)
            begin
                wr_addr_reg <= s_axi_awaddr;
                aw_got_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wr_data_reg <= s_axi_wdata;
                wr_strb_reg <= s_axi_wstrb;
                w_got_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_reg && w_got_reg && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_SLVERR;
                if (wr_index == `CLOCK_OUT_SELECT_INDEX)
                begin
                    clock_out_select_reg <= clk_merge[9:0];
                    s_axi_bresp <= `RESP_OKAY;
                end
                if (wr_index == `PORT_C_SELECT_INDEX)
                begin
                    port_c_function_select_reg <= gps_merge[3:0];
                    s_axi_bresp <= `RESP_OKAY;
                end
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel

    // A read is answered on the cycle after its address is taken.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
            if (!s_axi_rvalid && !s_axi_arready)
                s_axi_arready <= 1'b1;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (rd_index == `CLOCK_OUT_SELECT_INDEX)
                    s_axi_rdata <= {22'h00_0000, clock_out_select_reg};
                else if (rd_index == `PORT_C_SELECT_INDEX)
                    s_axi_rdata <= {28'h000_0000, port_c_function_select_reg};
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Clock-output pin

    wire [4:0] clk_src;
    wire clk_disable;
    wire [3:0] port_b_alt;
    reg clock_mux;

    assign clk_src = clock_out_select_reg[`CLK_SRC_MSB:`CLK_SRC_LSB];
    assign clk_disable = clock_out_select_reg[`CLK_DISABLE_BIT];
    assign port_b_alt = clock_out_select_reg[`PORT_B_ALT_MSB:`PORT_B_ALT_LSB];

    // Clocks cannot pass a flip-flop, so the pin is driven straight from this mux.
    // Factory-test codes are not routed here; they hold the pin low.
    // single mux path
    always @*
    begin
        case (clk_src)
            `CLK_SRC_SYSTEM: clock_mux = system_clock;
            `CLK_SRC_OSCILLATOR: clock_mux = oscillator_clock;
            `CLK_SRC_SYNTH: clock_mux = clock_generator_fout;
            `CLK_SRC_ADC_A: clock_mux = adc_a_clock;
            `CLK_SRC_ADC_B: clock_mux = adc_b_clock;
            default: clock_mux = 1'b0;
        endcase
    end

    // Output buffer enable follows the disable bit; low level while floated.
    // tri-state control
    always @*
    begin
        clock_output_pin_oe = !clk_disable;
        clock_output_pin_o = clock_mux & !clk_disable;
    end

    // ==========================================================
    // Port-B upper pins

    wire [3:0] port_b_alt_clock;
    wire [3:0] port_b_periph_out;

    // Index 0..3 stands for pins 4..7.
    // pin 7 source
    assign port_b_alt_clock = {master_oscillator_clock, secondary_system_clock,
                               system_clock, clock_generator_prescaler};
    assign port_b_periph_out = (port_b_alt & port_b_alt_clock) | (~port_b_alt & address_high);

    // Peripheral mode always drives; otherwise the pin is plain GPIO.
    // enable has priority
    always @*
    begin
        port_b_pin_o = (port_b_peripheral_enable & port_b_periph_out) |
                       (~port_b_peripheral_enable & port_b_gpio_out);
        port_b_pin_oe = port_b_peripheral_enable | port_b_direction;
    end

    // ==========================================================
    // Port-C shared pins

    wire [3:0] pc_timer_mode;
    wire [3:0] pc_spi_mode;

    // Bitwise terms keep every pin on its own control bits.
    // per-pin control
    assign pc_timer_mode = port_c_peripheral_enable & ~port_c_function_select_reg;
    assign pc_spi_mode = port_c_peripheral_enable & port_c_function_select_reg;

    // Drive selection per pin; the decoder has no drive term at all.
    // GPIO direction
    always @*
    begin
        port_c_pin_oe = (~port_c_peripheral_enable & port_c_direction) |
                        (pc_timer_mode & timer_output_enable) |
                        (pc_spi_mode & spi2_oe);
        port_c_pin_o = (~port_c_peripheral_enable & port_c_gpio_out) |
                       (pc_timer_mode & timer_b_out) |
                       (pc_spi_mode & spi2_out);
    end

    // ==========================================================
    // Port-C input sampling

    reg [3:0] pin_meta_reg;
    reg [3:0] pin_sync_reg;

    // Pins are asynchronous; two stages before any use, a third stage routes them.
    // Routing adds one cycle, so consumers see pins three cycles late.
    // pin 0..3 functions
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
            port_c_gpio_in <= 4'h0;
            timer_b_in <= 4'h0;
            decoder_in <= 4'h0;
            spi2_in <= 4'h0;
        end
        else
        begin
            pin_meta_reg <= port_c_pin_i;
            pin_sync_reg <= pin_meta_reg;
            port_c_gpio_in <= pin_sync_reg;
            timer_b_in <= pin_sync_reg & pc_timer_mode & ~timer_output_enable;
            decoder_in <= pin_sync_reg & pc_timer_mode;
            spi2_in <= pin_sync_reg & pc_spi_mode;
        end
    end

endmodule
`default_nettype wire

// >>> verif/pin_select_monitor.sv
// Checker of pin routing and bus handshakes for the pin select block.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module pin_select_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic clock_output_pin_o,
    input wire logic clock_output_pin_oe,
    input wire logic [3:0] port_b_peripheral_enable,
    input wire logic [3:0] port_b_direction,
    input wire logic [3:0] port_b_gpio_out,
    input wire logic [3:0] port_b_pin_o,
    input wire logic [3:0] port_b_pin_oe,
    input wire logic [3:0] port_c_peripheral_enable,
    input wire logic [3:0] port_c_direction,
    input wire logic [3:0] port_c_gpio_out,
    input wire logic [3:0] timer_output_enable,
    input wire logic [3:0] spi2_oe,
    input wire logic [3:0] port_c_pin_o,
    input wire logic [3:0] port_c_pin_oe,
    input wire logic [3:0] timer_b_in,
    input wire logic [3:0] decoder_in,
    input wire logic [3:0] spi2_in
);
    // All checks share the bus clock and its reset.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A response must stand until the master takes it.
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before it was taken.");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped before it was taken.");
    rsvd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0)
        else $error("Unused read bits are not zero.");
    clk_oe_write_a: assert property ($changed(clock_output_pin_oe) |-> $rose(s_axi_bvalid))
        else $error("Clock pin enable moved without a register write.");
    clk_off_a: assert property (!clock_output_pin_oe |-> !clock_output_pin_o)
        else $error("Floating clock pin still carries a clock.");
    pb_gpio_a: assert property (((~port_b_peripheral_enable) &
        ((port_b_pin_oe ^ port_b_direction) | (port_b_pin_o ^ port_b_gpio_out))) == 4'h0)
        else $error("Port B general pin not steered by its own controls.");
    pb_periph_a: assert property ((port_b_peripheral_enable & ~port_b_pin_oe) == 4'h0)
        else $error("Port B peripheral pin not driven.");
    pc_gpio_a: assert property (((~port_c_peripheral_enable) &
        ((port_c_pin_oe ^ port_c_direction) | (port_c_pin_o ^ port_c_gpio_out))) == 4'h0)
        else $error("Port C general pin not steered by its own controls.");
    pc_dir_a: assert property ((port_c_peripheral_enable & port_c_pin_oe
        & ~timer_output_enable & ~spi2_oe) == 4'h0)
        else $error("Port C peripheral pin driven without an enable.");
    // Routed inputs are registered, so they follow the controls of the cycle before.
    dec_spi_a: assert property (((decoder_in & spi2_in) |
        ((decoder_in | spi2_in) & ~$past(port_c_peripheral_enable))) == 4'h0)
        else $error("Pin sampled by decoder and serial unit at once.");
    tmr_dec_a: assert property ((timer_b_in &
        (~decoder_in | $past(timer_output_enable))) == 4'h0)
        else $error("Timer input seen where the decoder saw none.");
    // Main scenarios reached.
    cover property (clock_output_pin_oe && clock_output_pin_o);
    cover property (|spi2_in);
    cover property (|timer_b_in);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind clock_out_and_port_pin_select pin_select_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe),
    .port_b_peripheral_enable(port_b_peripheral_enable), .port_b_direction(port_b_direction),
    .port_b_gpio_out(port_b_gpio_out), .port_b_pin_o(port_b_pin_o), .port_b_pin_oe(port_b_pin_oe),
    .port_c_peripheral_enable(port_c_peripheral_enable), .port_c_direction(port_c_direction),
    .port_c_gpio_out(port_c_gpio_out), .timer_output_enable(timer_output_enable),
    .spi2_oe(spi2_oe), .port_c_pin_o(port_c_pin_o), .port_c_pin_oe(port_c_pin_oe),
    .timer_b_in(timer_b_in), .decoder_in(decoder_in), .spi2_in(spi2_in));
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the clock-output and port pin select block.
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_defines.vh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb;
    // ==========================================================
    // Stimulus and observed signals
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ck_o, ck_oe;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] src = '0;
    logic [3:0] b_pe = '0, b_dir = '0, b_gpo = '0, addr_hi = '0, b_o, b_oe, sel = '0;
    logic [3:0] c_pe = '0, c_dir = '0, c_gpo = '0, t_oe = '0, t_out = '0, s_out = '0, s_oe = '0;
    logic [3:0] c_pin = '0, c_o, c_oe, c_gpi, t_in, d_in, s_in;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    // The clock runs at 40 MHz; the counter cuts a hung run short.
    always #12.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    // ==========================================================
    // Device under test
    clock_out_and_port_pin_select i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .system_clock(src[0]), .oscillator_clock(src[1]),
        .clock_generator_fout(src[2]), .adc_a_clock(src[3]), .adc_b_clock(src[4]),
        .master_oscillator_clock(src[5]), .secondary_system_clock(src[6]),
        .clock_generator_prescaler(src[7]), .clock_output_pin_o(ck_o), .clock_output_pin_oe(ck_oe),
        .port_b_peripheral_enable(b_pe), .port_b_direction(b_dir), .port_b_gpio_out(b_gpo),
        .address_high(addr_hi), .port_b_pin_o(b_o), .port_b_pin_oe(b_oe),
        .port_c_peripheral_enable(c_pe), .port_c_direction(c_dir), .port_c_gpio_out(c_gpo),
        .timer_output_enable(t_oe), .timer_b_out(t_out), .spi2_out(s_out), .spi2_oe(s_oe),
        .port_c_pin_i(c_pin), .port_c_pin_o(c_o), .port_c_pin_oe(c_oe), .port_c_gpio_in(c_gpi),
        .timer_b_in(t_in), .decoder_in(d_in), .spi2_in(s_in));
    // ==========================================================
    // Bus tasks: each starts just after a clock edge and leaves one edge after its response.
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            aw_ok = aw_ok | (awready === 1'b1);
            w_ok = w_ok | (wready === 1'b1);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        `CHK("rdata", ed, rdata)
        `CHK("rresp", er, rresp)
        @(posedge aclk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd(`CLOCK_OUT_SELECT_ADDR, 32'h0000_0020, `RESP_OKAY);
        rd(`PORT_C_SELECT_ADDR, 32'h0000_0000, `RESP_OKAY);
        `CHK("clk_oe_rst", 1'b0, ck_oe)
    endtask
    task automatic t_clk();
        logic [4:0] codes [5];
        codes = '{`CLK_SRC_SYSTEM, `CLK_SRC_OSCILLATOR, `CLK_SRC_SYNTH, `CLK_SRC_ADC_A,
            `CLK_SRC_ADC_B};
        // Only codes open to software are used here; the chosen source goes high alone, then low alone.
        for (int i = 0; i < 5; i++)
        begin
            wr(`CLOCK_OUT_SELECT_ADDR, {27'h0, codes[i]}, 4'hf, `RESP_OKAY);
            src <= 8'h01 << i;
            #1;
            `CHK("clk_hi", 2'b11, {ck_oe, ck_o})
            @(posedge aclk);
            src <= ~(8'h01 << i);
            #1;
            `CHK("clk_lo", 2'b10, {ck_oe, ck_o})
            @(posedge aclk);
        end
        wr(`CLOCK_OUT_SELECT_ADDR, 32'h0000_0020, 4'hf, `RESP_OKAY);
        #1;
        `CHK("clk_float", 1'b0, ck_oe)
        @(posedge aclk);
    endtask
    task automatic t_rsvd();
        wr(`CLOCK_OUT_SELECT_ADDR, 32'hffff_fc20, 4'hf, `RESP_OKAY);
        rd(`CLOCK_OUT_SELECT_ADDR, 32'h0000_0020, `RESP_OKAY);
        wr(`CLOCK_OUT_SELECT_ADDR, 32'h0000_03c0, 4'h1, `RESP_OKAY);
        rd(`CLOCK_OUT_SELECT_ADDR, 32'h0000_00c0, `RESP_OKAY);
        wr(`PORT_C_SELECT_ADDR, 32'hffff_fff0, 4'hf, `RESP_OKAY);
        rd(`PORT_C_SELECT_ADDR, 32'h0000_0000, `RESP_OKAY);
        wr(32'h0000_0030, 32'h0000_000f, 4'hf, `RESP_SLVERR);
        rd(32'h0000_0030, 32'h0000_0000, `RESP_SLVERR);
    endtask
    // Port B expectation: clocks per pin 4..7 are prescaler, system, secondary, oscillator.
    function automatic logic [7:0] pb_exp(input logic [3:0] alt);
        logic [3:0] ck;
        ck = {src[5], src[6], src[0], src[7]};
        return {b_pe | b_dir, (b_pe & ((alt & ck) | (~alt & addr_hi))) | (~b_pe & b_gpo)};
    endfunction
    task automatic t_port_b();
        for (int j = 0; j < 2; j++)
        begin
            wr(`CLOCK_OUT_SELECT_ADDR, j ? 32'h0000_02a0 : 32'h0000_0160, 4'hf, `RESP_OKAY);
            for (int i = 0; i < 9; i++)
            begin
                src <= (i < 8) ? 8'h01 << i : 8'h00;
                addr_hi <= (i == 8) ? 4'hf : 4'h0;
                b_pe <= i[0] ? 4'hf : 4'h3;
                b_dir <= 4'h5;
                b_gpo <= 4'h9;
                #1;
                `CHK("port_b", pb_exp(j ? 4'ha : 4'h5), {b_oe, b_o})
                @(posedge aclk);
            end
        end
    endtask
    // Per-pin settings differ so that a pin borrowing a neighbour's control shows up.
    task automatic t_port_c();
        logic [3:0] e_oe, e_o;
        for (int i = 0; i < 4; i++)
        begin
            sel = 4'h3 << i;
            wr(`PORT_C_SELECT_ADDR, {28'h0, sel}, 4'hf, `RESP_OKAY);
            c_pe <= 4'he ^ i[3:0];
            c_dir <= 4'h5;
            c_gpo <= 4'h3;
            t_oe <= 4'h9;
            t_out <= 4'ha;
            s_out <= 4'h6;
            s_oe <= 4'h5;
            c_pin <= 4'hd ^ sel;
            repeat (3) @(posedge aclk);
            #1;
            e_oe = (~c_pe & c_dir) | (c_pe & ~sel & t_oe) | (c_pe & sel & s_oe);
            e_o = (~c_pe & c_gpo) | (c_pe & ~sel & t_out) | (c_pe & sel & s_out);
            `CHK("pc_oe", e_oe, c_oe)
            `CHK("pc_o", e_o, c_o)
            `CHK("gpio_in", c_pin, c_gpi)
            `CHK("timer_in", c_pin & c_pe & ~sel & ~t_oe, t_in)
            `CHK("dec_in", c_pin & c_pe & ~sel, d_in)
            `CHK("spi_in", c_pin & c_pe & sel, s_in)
            @(posedge aclk);
        end
    endtask
    // ==========================================================
    // Verdict and main sequence
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_clk();
        t_rsvd();
        t_port_b();
        t_port_c();
        test_done();
    end
endmodule
`default_nettype wire
